/* core/hls_loop_regs.sv */
// storage for the two sets of loop start, end and count registers
`timescale 1ns/10ps
module hls_loop_regs
    import hls_pkg::*;
(
    input  wire logic mclk,
    input  wire logic srst,
    hls_wr_if.mem     wr
);
    logic [31:0] start_r      [HLS_NUM_LOOPS];
    logic [31:0] end_r        [HLS_NUM_LOOPS];
    logic [31:0] count_r      [HLS_NUM_LOOPS];
    logic [31:0] next_start_r [HLS_NUM_LOOPS];
    logic [31:0] next_end_r   [HLS_NUM_LOOPS];
    logic [31:0] next_count_r [HLS_NUM_LOOPS];

    always_comb begin
        for (int i = 0; i < HLS_NUM_LOOPS; i++) begin
            next_start_r[i] = start_r[i];
            next_end_r[i]   = end_r[i];
            next_count_r[i] = count_r[i];
            // only the indexed set changes; the other loop is untouched
            if (wr.idx == i[0]) begin // RL12
                if (wr.we_start) begin
                    next_start_r[i] = wr.start_val & HLS_ALIGN_MASK; // RL3
                end
                if (wr.we_end) begin
                    next_end_r[i] = wr.end_val & HLS_ALIGN_MASK; // RL3
                end
                if (wr.we_count) begin
                    next_count_r[i] = wr.count_val;
                end
            end
        end
    end

    always_ff @(posedge mclk) begin
        for (int i = 0; i < HLS_NUM_LOOPS; i++) begin
            if (srst) begin
                start_r[i] <= HLS_RESET_VALUE;
                end_r[i]   <= HLS_RESET_VALUE;
                count_r[i] <= HLS_RESET_VALUE;
            end else begin
                start_r[i] <= next_start_r[i];
                end_r[i]   <= next_end_r[i];
                count_r[i] <= next_count_r[i];
            end
        end
    end

    assign wr.start_q = start_r;
    assign wr.end_q   = end_r;
    assign wr.count_q = count_r;
endmodule : hls_loop_regs

/* core/hls_loop_setup.sv */
// hardware-loop setup instruction decoder and executor
//
// Overview of operation
// RL1: immediate start form writes start = pc + (long imm << 2).
// RL2: register start/end forms copy source register, ignoring its two low bits.
// RL3: stored start and end addresses always have two low bits zero.
// RL4: immediate end form writes end = pc + (long imm << 2).
// RL5: long forms update one parameter; count from long imm or source register.
// RL6: short immediate setup: start pc+4, end pc+(short imm<<2), count long imm.
// RL7: short register setup: start pc+4, end pc+(long imm<<2), count from register.
// RL8: software places loop body right after a short setup instruction.
// RL9: short immediate end offset from bits 19:15, count from bits 31:20.
// RL10: recognised by opcode 0101011, funct3 100; index bit 7, subop bits 11:8.
// RL11: subop codes 0000 through 0111 select the eight setup instructions.
// RL12: two independent register sets selected by loop index 0 or 1.
// RL13: instructions exist only when the custom extension parameter is 1.
// RL14: software finishes configuring a loop before entering its body.
// RL15: nonzero fixed-zero fields make a setup encoding illegal.
`timescale 1ns/10ps
module hls_loop_setup
    import hls_pkg::*;
#(
    parameter bit CUSTOM_EXT_ENABLE_PARAM = 1'b1
)
(
    input  wire logic        mclk,
    input  wire logic        srst,
    input  wire logic        insn_valid,
    input  wire logic [31:0] insn,
    input  wire logic [31:0] insn_pc,
    input  wire logic [31:0] rs1_value,
    output logic             insn_match,
    output logic             insn_illegal,
    output logic [31:0]      loop0_start,
    output logic [31:0]      loop0_end,
    output logic [31:0]      loop0_count,
    output logic [31:0]      loop1_start,
    output logic [31:0]      loop1_end,
    output logic [31:0]      loop1_count
);
    // ****************************************************************
    // field extraction
    // ****************************************************************
    hls_wr_if wr ();

    logic [6:0]  opc;
    logic [2:0]  f3;
    logic [3:0]  loop_subop_field;
    logic [4:0]  rs1_field;
    logic [11:0] long_unsigned_imm;
    logic [4:0]  short_unsigned_imm;
    logic        is_family;
    logic        fields_ok;
    logic        do_write;

    function automatic logic [31:0] hls_pc_offset(input logic [31:0] pc, input logic [11:0] imm);
        hls_pc_offset = pc + ({20'h00000, imm} << HLS_ADDR_SHIFT);
    endfunction : hls_pc_offset

    assign opc                = insn[HLS_OPC_LSB +: 7];
    assign f3                 = insn[HLS_F3_LSB +: 3];
    assign loop_subop_field   = insn[HLS_SUBOP_LSB +: 4];
    assign rs1_field          = insn[HLS_RS1_LSB +: 5];
    assign short_unsigned_imm = insn[HLS_RS1_LSB +: 5]; // RL9
    assign long_unsigned_imm  = insn[HLS_LIMM_LSB +: 12]; // RL9

    // disabled parameter makes the whole family unrecognised
    assign is_family = CUSTOM_EXT_ENABLE_PARAM && insn_valid
                       && opc == HLS_OPCODE && f3 == HLS_FUNCT3; // RL10 RL13

    // ****************************************************************
    // decode and operand selection
    // ****************************************************************
    always_comb begin
        fields_ok    = 1'b0;
        wr.we_start  = 1'b0;
        wr.we_end    = 1'b0;
        wr.we_count  = 1'b0;
        wr.start_val = HLS_RESET_VALUE;
        wr.end_val   = HLS_RESET_VALUE;
        wr.count_val = HLS_RESET_VALUE;
        wr.idx       = insn[HLS_IDX_BIT]; // RL10 RL12
        case (loop_subop_field) // RL11
            HLS_SET_START_IMM: begin
                fields_ok    = rs1_field == HLS_RS1_ZERO; // RL15
                wr.we_start  = 1'b1; // RL5
                wr.start_val = hls_pc_offset(insn_pc, long_unsigned_imm); // RL1
            end
            HLS_SET_START_REG: begin
                fields_ok    = long_unsigned_imm == HLS_LIMM_ZERO; // RL15
                wr.we_start  = 1'b1;
                wr.start_val = rs1_value & HLS_ALIGN_MASK; // RL2
            end
            HLS_SET_END_IMM: begin
                fields_ok  = rs1_field == HLS_RS1_ZERO; // RL15
                wr.we_end  = 1'b1;
                wr.end_val = hls_pc_offset(insn_pc, long_unsigned_imm); // RL4
            end
            HLS_SET_END_REG: begin
                fields_ok  = long_unsigned_imm == HLS_LIMM_ZERO; // RL15
                wr.we_end  = 1'b1;
                wr.end_val = rs1_value & HLS_ALIGN_MASK; // RL2
            end
            HLS_SET_COUNT_IMM: begin
                fields_ok    = rs1_field == HLS_RS1_ZERO; // RL15
                wr.we_count  = 1'b1;
                wr.count_val = {20'h00000, long_unsigned_imm}; // RL5
            end
            HLS_SET_COUNT_REG: begin
                fields_ok    = long_unsigned_imm == HLS_LIMM_ZERO; // RL15
                wr.we_count  = 1'b1;
                wr.count_val = rs1_value; // RL5
            end
            HLS_SHORT_SETUP_IMM: begin
                fields_ok    = 1'b1;
                wr.we_start  = 1'b1;
                wr.we_end    = 1'b1;
                wr.we_count  = 1'b1;
                wr.start_val = insn_pc + HLS_NEXT_INSN; // RL6
                wr.end_val   = hls_pc_offset(insn_pc, {7'h00, short_unsigned_imm}); // RL6 RL9
                wr.count_val = {20'h00000, long_unsigned_imm}; // RL6
            end
            HLS_SHORT_SETUP_REG: begin
                fields_ok    = 1'b1;
                wr.we_start  = 1'b1;
                wr.we_end    = 1'b1;
                wr.we_count  = 1'b1;
                // body is assumed to start at the following instruction
                wr.start_val = insn_pc + HLS_NEXT_INSN; // RL7 RL8
                wr.end_val   = hls_pc_offset(insn_pc, long_unsigned_imm); // RL7
                wr.count_val = rs1_value; // RL7
            end
            default: begin
                fields_ok = 1'b0;
            end
        endcase
        do_write = is_family && fields_ok;
        // illegal encodings must leave every loop register untouched
        if (!do_write) begin // RL15
            wr.we_start = 1'b0;
            wr.we_end   = 1'b0;
            wr.we_count = 1'b0;
        end
    end

    assign insn_match   = do_write;
    assign insn_illegal = is_family && !fields_ok; // RL15

    // ****************************************************************
    // loop register storage
    // ****************************************************************
    hls_loop_regs u_regs (
        .mclk (mclk),
        .srst (srst),
        .wr   (wr)
    );

    // outputs reflect stored state; software must finish setup before the body (RL14)
    assign loop0_start = wr.start_q[0];
    assign loop0_end   = wr.end_q[0];
    assign loop0_count = wr.count_q[0];
    assign loop1_start = wr.start_q[1];
    assign loop1_end   = wr.end_q[1];
    assign loop1_count = wr.count_q[1];
endmodule : hls_loop_setup

/* shared/hls_pkg.sv */
// package of constants and types for the hardware-loop setup decoder
package hls_pkg;
    // ****************************************************************
    // instruction fields
    // ****************************************************************
    localparam logic [6:0]  HLS_OPCODE       = 7'h2B;
    localparam logic [2:0]  HLS_FUNCT3       = 3'h4;
    localparam int          HLS_OPC_LSB      = 0;
    localparam int          HLS_IDX_BIT      = 7;
    localparam int          HLS_SUBOP_LSB    = 8;
    localparam int          HLS_F3_LSB       = 12;
    localparam int          HLS_RS1_LSB      = 15;
    localparam int          HLS_LIMM_LSB     = 20;
    localparam int          HLS_ADDR_SHIFT   = 2;
    localparam logic [31:0] HLS_NEXT_INSN    = 32'h0000_0004;
    localparam logic [31:0] HLS_ALIGN_MASK   = 32'hFFFF_FFFC;
    localparam logic [11:0] HLS_LIMM_ZERO    = 12'h000;
    localparam logic [4:0]  HLS_RS1_ZERO     = 5'h00;
    localparam logic [31:0] HLS_RESET_VALUE  = 32'h0000_0000;
    localparam int          HLS_NUM_LOOPS    = 2;

    // ****************************************************************
    // sub-operation codes
    // ****************************************************************
    typedef enum logic [3:0] {
        HLS_SET_START_IMM   = 4'h0,
        HLS_SET_START_REG   = 4'h1,
        HLS_SET_END_IMM     = 4'h2,
        HLS_SET_END_REG     = 4'h3,
        HLS_SET_COUNT_IMM   = 4'h4,
        HLS_SET_COUNT_REG   = 4'h5,
        HLS_SHORT_SETUP_IMM = 4'h6,
        HLS_SHORT_SETUP_REG = 4'h7
    } hls_subop_e;
endpackage : hls_pkg

/* shared/hls_wr_if.sv */
// interface carrying loop register write requests to the storage
`timescale 1ns/10ps
interface hls_wr_if;
    logic        idx;
    logic        we_start;
    logic        we_end;
    logic        we_count;
    logic [31:0] start_val;
    logic [31:0] end_val;
    logic [31:0] count_val;
    logic [31:0] start_q [2];
    logic [31:0] end_q   [2];
    logic [31:0] count_q [2];

    modport dec (output idx, we_start, we_end, we_count, start_val, end_val, count_val,
                 input start_q, end_q, count_q);
    modport mem (input idx, we_start, we_end, we_count, start_val, end_val, count_val,
                 output start_q, end_q, count_q);
endinterface : hls_wr_if

/* tb/hardware_loop_setup_test.sv */
// self-checking bench for the hardware-loop setup decoder
`timescale 1ns/10ps
module hardware_loop_setup_test;
    import hls_pkg::*;
    logic              mclk = 1'b0;
    logic              srst = 1'b1;
    logic              insn_valid, insn_match, insn_illegal, off_match, off_illegal, l;
    logic [31:0]       insn, insn_pc, rs1_value, pc, rs;
    // each element has its own port driver, so the loop outputs land on a net
    wire  [5:0][31:0]  lp;
    logic [5:0][31:0]  exp_lp;
    logic [11:0]       li;
    logic [4:0]        r;
    logic [3:0]        op;
    int                failures = 0;
    int                n_compared = 0;
    int                cycles = 0;
    int                b;

    always #2.5 mclk = ~mclk;
    hls_pipe_model pipe (.mclk(mclk), .insn_valid(insn_valid), .insn(insn), .insn_pc(insn_pc), .rs1_value(rs1_value));
    hls_loop_setup uut (.mclk(mclk), .srst(srst), .insn_valid(insn_valid), .insn(insn), .insn_pc(insn_pc),
        .rs1_value(rs1_value), .insn_match(insn_match), .insn_illegal(insn_illegal), .loop0_start(lp[0]),
        .loop0_end(lp[1]), .loop0_count(lp[2]), .loop1_start(lp[3]), .loop1_end(lp[4]), .loop1_count(lp[5]));
    hls_loop_setup #(.CUSTOM_EXT_ENABLE_PARAM(1'b0)) uut_off (.mclk(mclk), .srst(srst), .insn_valid(insn_valid),
        .insn(insn), .insn_pc(insn_pc), .rs1_value(rs1_value), .insn_match(off_match), .insn_illegal(off_illegal),
        .loop0_start(), .loop0_end(), .loop0_count(), .loop1_start(), .loop1_end(), .loop1_count());

    task automatic cmp(input string name, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", name, e, g);
        end
    endtask : cmp
    task automatic check_loops;
        for (int i = 0; i < 6; i++) cmp("loop register", exp_lp[i], lp[i]);
    endtask : check_loops
    // loop registers seen here still carry the previous instruction, so back-to-back issue is checked too
    task automatic send(input logic [31:0] w, input logic m, input logic il);
        pipe.issue(1'b1, w, pc, rs);
        #1;
        cmp("insn_match", {31'h0, m}, {31'h0, insn_match});
        cmp("insn_illegal", {31'h0, il}, {31'h0, insn_illegal});
        cmp("disabled flags", 32'h0, {30'h0, off_match, off_illegal});
        check_loops;
    endtask : send
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : final_report

    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 400) begin
            failures++;
            final_report;
        end
    end

    initial begin
        exp_lp = '0;
        repeat (12) @(posedge mclk);
        srst <= 1'b0;
        #1;
        check_loops;
        for (int k = 0; k < 16; k++) begin
            op = k[4:1];
            l  = k[0];
            b  = l ? 3 : 0;
            li = {8'hA5, k[3:0]};
            r  = (op inside {4'h0, 4'h2, 4'h4}) ? 5'h00 : 5'h13;
            pc = {24'h000100, k[3:0], 4'h0};
            rs = {28'hDEADBEE, k[3:0]};
            if (op inside {4'h1, 4'h3, 4'h5}) li = 12'h000;
            send({li, r, HLS_FUNCT3, op, l, HLS_OPCODE}, 1'b1, 1'b0);
            case (op)
                4'h0: exp_lp[b] = (pc + {18'h0, li, 2'h0}) & HLS_ALIGN_MASK;
                4'h1: exp_lp[b] = rs & HLS_ALIGN_MASK;
                4'h2: exp_lp[b + 1] = (pc + {18'h0, li, 2'h0}) & HLS_ALIGN_MASK;
                4'h3: exp_lp[b + 1] = rs & HLS_ALIGN_MASK;
                4'h4: exp_lp[b + 2] = {20'h0, li};
                4'h5: exp_lp[b + 2] = rs;
                4'h6: exp_lp[b + 2 -: 3] = {20'h0, li, (pc + {25'h0, r, 2'h0}) & HLS_ALIGN_MASK, pc + HLS_NEXT_INSN};
                default: exp_lp[b + 2 -: 3] = {rs, (pc + {18'h0, li, 2'h0}) & HLS_ALIGN_MASK, pc + HLS_NEXT_INSN};
            endcase
        end
        for (int k = 0; k < 14; k++) begin
            op = k < 8 ? {1'b1, k[2:0]} : 4'(k - 8);
            li = (k >= 8 && op[0]) ? 12'h801 : 12'h000;
            r  = (k >= 8 && !op[0]) ? 5'h11 : 5'h00;
            send({li, r, HLS_FUNCT3, op, k[0], HLS_OPCODE}, 1'b0, 1'b1);
        end
        send({12'h004, 5'h00, 3'h5, 4'h4, 1'b0, HLS_OPCODE}, 1'b0, 1'b0);
        send({12'h004, 5'h00, HLS_FUNCT3, 4'h4, 1'b0, 7'h0B}, 1'b0, 1'b0);
        // a legal word without valid must neither match nor write
        pipe.issue(1'b0, {12'hFFF, 5'h00, HLS_FUNCT3, 4'h4, 1'b0, HLS_OPCODE}, pc, rs);
        #1;
        cmp("insn_match", 32'h0, {31'h0, insn_match});
        pipe.issue(1'b0, 32'h0, ~pc, ~rs);
        #1;
        check_loops;
        @(posedge mclk) srst <= 1'b1;
        @(posedge mclk) srst <= 1'b0;
        exp_lp = '0;
        #1;
        check_loops;
        // first instruction right after a mid-run reset must still be taken
        send({12'h00C, 5'h00, HLS_FUNCT3, 4'h4, 1'b1, HLS_OPCODE}, 1'b1, 1'b0);
        exp_lp[5] = 32'h0000_000C;
        pipe.issue(1'b0, 32'h0, pc, rs);
        #1;
        check_loops;
        final_report;
    end
endmodule : hardware_loop_setup_test

/* tb/hls_loop_setup_chk.sv */
// concurrent checks of loop setup decoding and loop register updates
`timescale 1ns/10ps
module hls_loop_setup_chk
    import hls_pkg::*;
#(
    parameter bit CUSTOM_EXT_ENABLE_PARAM = 1'b1
)
(
    input wire logic        mclk,
    input wire logic        srst,
    input wire logic        insn_valid,
    input wire logic [31:0] insn,
    input wire logic [31:0] insn_pc,
    input wire logic [31:0] rs1_value,
    input wire logic        insn_match,
    input wire logic        insn_illegal,
    input wire logic [31:0] loop0_start,
    input wire logic [31:0] loop0_end,
    input wire logic [31:0] loop0_count,
    input wire logic [31:0] loop1_start,
    input wire logic [31:0] loop1_end,
    input wire logic [31:0] loop1_count
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);
    wire logic [3:0]   op     = insn[11:8];
    wire logic         hit    = insn_valid && insn_match;
    wire logic         opf    = CUSTOM_EXT_ENABLE_PARAM && insn[6:0] == HLS_OPCODE && insn[14:12] == HLS_FUNCT3;
    wire logic [31:0]  limm   = {20'h0, insn[31:20]};
    wire logic [31:0]  lofs   = (insn_pc + {18'h0, insn[31:20], 2'h0}) & HLS_ALIGN_MASK;
    wire logic [31:0]  sofs   = (insn_pc + {25'h0, insn[19:15], 2'h0}) & HLS_ALIGN_MASK;
    wire logic [31:0]  nxt    = (insn_pc + HLS_NEXT_INSN) & HLS_ALIGN_MASK;
    wire logic [95:0]  lp0    = {loop0_start, loop0_end, loop0_count};
    wire logic [191:0] lp_all = {lp0, loop1_start, loop1_end, loop1_count};

    dec_fields_a: assert property (insn_match |-> opf && !insn[11])
        else $error("match on a foreign encoding");
    off_quiet_a: assert property (!CUSTOM_EXT_ENABLE_PARAM |-> !insn_match && !insn_illegal)
        else $error("disabled extension decoded something");
    subop_bad_a: assert property (insn_valid && opf && insn[11] |-> insn_illegal && !insn_match)
        else $error("unknown subop not refused");
    zero_field_a: assert property (insn_valid && opf && op < 4'h6 && (op[0] ? limm != 0 : insn[19:15] != 5'h0)
        |-> insn_illegal && !insn_match) else $error("fixed-zero field not refused");
    refuse_hold_a: assert property (insn_valid && insn_illegal |=> $stable(lp_all))
        else $error("refused encoding changed a loop register");
    word_align_a: assert property (~|{loop0_start[1:0], loop0_end[1:0], loop1_start[1:0], loop1_end[1:0]})
        else $error("loop address not word aligned");
    start_imm_a: assert property (hit && op == 4'h0 && !insn[7] |=> loop0_start == $past(lofs))
        else $error("immediate start value wrong");
    count_imm_a: assert property (hit && op == 4'h4 && !insn[7]
        |=> loop0_count == $past(limm) && $stable(loop0_start) && $stable(loop0_end)) else $error("count form wrong");
    short_imm_a: assert property (hit && op == 4'h6 && insn[7]
        |=> loop1_start == $past(nxt) && loop1_end == $past(sofs) && loop1_count == $past(limm))
        else $error("short immediate setup wrong");
    short_reg_a: assert property (hit && op == 4'h7 && !insn[7]
        |=> loop0_start == $past(nxt) && loop0_end == $past(lofs) && loop0_count == $past(rs1_value))
        else $error("short register setup wrong");
    loop_sep_a: assert property (hit && insn[7] |=> $stable(lp0))
        else $error("loop 1 write disturbed loop 0");

    cover property (hit && op == 4'h6);
    cover property (hit && op == 4'h7);
    cover property (insn_valid && insn_illegal);
endmodule : hls_loop_setup_chk

bind hls_loop_setup hls_loop_setup_chk #(.CUSTOM_EXT_ENABLE_PARAM(CUSTOM_EXT_ENABLE_PARAM)) chk (.mclk(mclk),
    .srst(srst), .insn_valid(insn_valid), .insn(insn), .insn_pc(insn_pc), .rs1_value(rs1_value),
    .insn_match(insn_match), .insn_illegal(insn_illegal), .loop0_start(loop0_start), .loop0_end(loop0_end),
    .loop0_count(loop0_count), .loop1_start(loop1_start), .loop1_end(loop1_end), .loop1_count(loop1_count));

/* tb/hls_pipe_model.sv */
// pipeline model that hands one instruction a cycle to the setup block
`timescale 1ns/10ps
module hls_pipe_model (
    input  wire logic   mclk,
    output logic        insn_valid,
    output logic [31:0] insn,
    output logic [31:0] insn_pc,
    output logic [31:0] rs1_value
);
    initial {insn_valid, insn, insn_pc, rs1_value} = '0;
    // setups are issued before the body, and a short-setup body starts at the next word
    task automatic issue(input logic v, input logic [31:0] w, input logic [31:0] pc, input logic [31:0] rs);
        @(posedge mclk);
        insn_valid <= v;
        insn       <= w;
        insn_pc    <= pc;
        rs1_value  <= rs;
    endtask : issue
endmodule : hls_pipe_model
